// ===== rbs_top.sv
// Reset and boot-mode sequencer top level
`timescale 1ns/100ps
`default_nettype none
`include "rbs_params.svh"
module rbs_top
(
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire rbs_pkg::straps_t STRAPS_IN,
  input wire logic BUS_REQ_IN,
  input wire logic BYTE_MEMORY_DMA_DONE_IN,
  input wire logic PM0_WRITTEN_IN,
  input wire logic ACK_LEVEL_IN,
  input wire logic FLAG2_OUT_VAL_IN,
  input wire logic FLAG2_OUT_DIR_IN,
  input wire logic [3:0] ADDR_WR_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  output logic CORE_RUN_OUT,
  output logic BYTE_MEMORY_DMA_START_OUT,
  output logic [5:0] BYTE_MEMORY_DMA_WORDS_OUT,
  output logic [13:0] START_ADDR_OUT,
  output logic START_EXT_OUT,
  output logic [6:0] MODE_STATUS_OUT,
  output logic [9:0] IMASK_OUT,
  output logic [3:0] STACK_PTR_OUT,
  output var rbs_pkg::mem_cfg_t MEM_CFG_OUT,
  output logic HOST_ACK_OUT,
  output logic HOST_ACK_OE_OUT,
  output logic FLAG2_OUT,
  output logic FLAG2_OE_OUT,
  output logic FLAG2_SAMPLE_OUT
);
  import rbs_pkg::*;

  // --------------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------------
  logic rst_n;
  rbs_rstsync rbs_rstsync_i
  (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .rstn_out(rst_n)
  );
  // Straps (shared pin included) and bus request are asynchronous pins
  logic [4:0] pins_s;
  rbs_sync #(.W(5)) rbs_sync_i
  (
    .clk_in(REF_CLK_IN),
    .d_in({STRAPS_IN, BUS_REQ_IN}),
    .q_out(pins_s)
  );
  straps_t straps_s;
  logic busreq_s;
  assign straps_s = pins_s[4:1];
  assign busreq_s = pins_s[0];

  // Strap capture tracks the pins while reset is held; the shared pin is released after reset
  straps_t cap_ff, nxt_cap;
  always_comb
  begin
    nxt_cap = cap_ff;
    if (!rst_n)
      nxt_cap = straps_s; // R6
  end
  always_ff @(posedge REF_CLK_IN)
  begin
    cap_ff <= nxt_cap;
  end

  // --------------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {S_RESET, S_DECIDE, S_BYTE_START, S_BYTE_WAIT, S_HOST_WAIT, S_RUN} seq_t;
  seq_t state_ff, nxt_state;
  straps_t straps_ff, nxt_straps;
  logic run_ff, nxt_run;
  logic bstart_ff, nxt_bstart;
  logic [13:0] start_ff, nxt_start;
  logic ext_ff, nxt_ext;
  mem_cfg_t cfg_ff, nxt_cfg;
  logic [6:0] mode_status_ff, nxt_mode_status;
  boot_sel_t sel;

  // Decode the latched straps into a boot path
  always_comb
  begin
    sel = BOOT_BAD;
    if (!straps_ff.mode_c && !straps_ff.mode_b && !straps_ff.mode_a)
      sel = BOOT_BYTE; // R7
    else if (!straps_ff.mode_c && straps_ff.mode_b && !straps_ff.mode_a)
      sel = BOOT_NONE; // R8
    else if (straps_ff.mode_c && !straps_ff.mode_b && straps_ff.mode_a)
      sel = BOOT_HOST; // R10
    else if (straps_ff.mode_c && !straps_ff.mode_b && !straps_ff.mode_a)
      sel = BOOT_BYTE; // R7
  end

  // Next-state logic; the core clock never stops, so no settle delay on release
  always_comb
  begin
    nxt_state = state_ff;
    nxt_straps = straps_ff;
    nxt_run = run_ff;
    nxt_bstart = 1'b0;
    nxt_start = start_ff;
    nxt_ext = ext_ff;
    nxt_cfg = cfg_ff;
    nxt_mode_status = mode_status_ff;
    unique case (state_ff)
      S_RESET:
      begin
        // Latch straps on the first clock after synchronised release
        nxt_straps = cap_ff; // R17 R6
        nxt_cfg.host_mode = cap_ff.mode_c; // R11
        nxt_cfg.ack_open_drain = cap_ff.mode_c & cap_ff.mode_d; // R11 R13
        nxt_cfg.overlay_a0_only = cap_ff.mode_c; // R15
        nxt_cfg.ext_exec_ok = ~cap_ff.mode_c; // R16
        nxt_state = S_DECIDE; // R3
      end
      S_DECIDE:
      begin
        // Booting waits while the bus is lent out
        if (busreq_s && sel != BOOT_NONE)
          nxt_state = S_DECIDE; // R4
        else
        begin
          unique case (sel)
            BOOT_BYTE:
            begin
              nxt_bstart = 1'b1; // R7
              nxt_state = S_BYTE_START;
            end
            BOOT_HOST: nxt_state = S_HOST_WAIT; // R10
            BOOT_NONE:
            begin
              nxt_start = `RBS_START_EXT; // R8 R9
              nxt_ext = 1'b1;
              nxt_run = 1'b1;
              nxt_state = S_RUN;
            end
            default:
            begin
              // Unlisted strap codes start from internal memory unbooted
              nxt_start = `RBS_START_INT;
              nxt_ext = 1'b0;
              nxt_run = 1'b1;
              nxt_state = S_RUN;
            end
          endcase
        end
      end
      S_BYTE_START: nxt_state = S_BYTE_WAIT;
      S_BYTE_WAIT:
      begin
        if (BYTE_MEMORY_DMA_DONE_IN)
        begin
          nxt_start = `RBS_START_INT; // R5 R7
          nxt_ext = 1'b0;
          nxt_run = 1'b1;
          nxt_state = S_RUN;
        end
      end
      S_HOST_WAIT:
      begin
        if (PM0_WRITTEN_IN)
        begin
          nxt_start = `RBS_START_INT; // R5 R10
          nxt_ext = 1'b0;
          nxt_run = 1'b1;
          nxt_state = S_RUN;
        end
      end
      S_RUN:
      begin
        // A software write to address 0 clears the mode status bits to their reset value
        if (WR_IN && ADDR_WR_IN == 4'h0)
          nxt_mode_status = `RBS_MODE_STATUS_RST;
      end
      default: nxt_state = S_RESET;
    endcase
  end

  // Registers; master reset values
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= S_RESET;
      straps_ff <= '0;
      run_ff <= 1'b0;
      bstart_ff <= 1'b0;
      start_ff <= `RBS_START_INT;
      ext_ff <= 1'b0;
      cfg_ff <= '0;
      mode_status_ff <= `RBS_MODE_STATUS_RST; // R1
    end
    else
    begin
      state_ff <= nxt_state;
      straps_ff <= nxt_straps;
      run_ff <= nxt_run;
      bstart_ff <= nxt_bstart;
      start_ff <= nxt_start;
      ext_ff <= nxt_ext;
      cfg_ff <= nxt_cfg;
      mode_status_ff <= nxt_mode_status;
    end
  end

  // --------------------------------------------------------------------------
  // Pins and outputs
  // --------------------------------------------------------------------------
  logic ack_ff, ack_oe_ff, f2_ff, f2oe_ff, f2s_ff, rd_ff;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [9:0] imask_ff;
  logic [3:0] sp_ff;
  logic [5:0] words_ff;

  // Read mux: status word and boot state
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (RD_IN)
    begin
      if (ADDR_WR_IN == 4'h0)
        nxt_rdata = {1'b0, mode_status_ff};
      else if (ADDR_WR_IN == 4'h1)
        nxt_rdata = {cfg_ff, straps_ff};
      else if (ADDR_WR_IN == 4'h2)
        nxt_rdata = {5'h00, state_ff};
    end
  end

  // Output flops; open-drain acknowledge only drives high, the external pull-down gives low
  always_ff @(posedge REF_CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b1;
      ack_oe_ff <= 1'b0;
      f2_ff <= 1'b0;
      f2oe_ff <= 1'b0; // R14
      f2s_ff <= 1'b0;
      rd_ff <= 1'b0;
      rdata_ff <= 8'h00;
      imask_ff <= `RBS_IMASK_RST; // R1
      sp_ff <= `RBS_SP_EMPTY; // R1
      words_ff <= `RBS_BOOT_WORDS; // R7
    end
    else
    begin
      ack_ff <= ACK_LEVEL_IN;
      if (!cfg_ff.host_mode)
        ack_oe_ff <= 1'b0;
      else if (cfg_ff.ack_open_drain)
        ack_oe_ff <= ACK_LEVEL_IN; // R13
      else
        ack_oe_ff <= 1'b1; // R12
      f2_ff <= FLAG2_OUT_VAL_IN;
      f2oe_ff <= FLAG2_OUT_DIR_IN & (state_ff != S_RESET); // R6
      f2s_ff <= straps_s.mode_c;
      rd_ff <= RD_IN;
      rdata_ff <= nxt_rdata;
      imask_ff <= imask_ff;
      sp_ff <= sp_ff;
      words_ff <= words_ff;
    end
  end

  assign RDATA_OUT = rdata_ff;
  assign CORE_RUN_OUT = run_ff;
  assign BYTE_MEMORY_DMA_START_OUT = bstart_ff;
  assign BYTE_MEMORY_DMA_WORDS_OUT = words_ff;
  assign START_ADDR_OUT = start_ff;
  assign START_EXT_OUT = ext_ff;
  assign MODE_STATUS_OUT = mode_status_ff;
  assign IMASK_OUT = imask_ff;
  assign STACK_PTR_OUT = sp_ff;
  assign MEM_CFG_OUT = cfg_ff;
  assign HOST_ACK_OUT = ack_ff;
  assign HOST_ACK_OE_OUT = ack_oe_ff;
  assign FLAG2_OUT = f2_ff;
  assign FLAG2_OE_OUT = f2oe_ff;
  assign FLAG2_SAMPLE_OUT = f2s_ff;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_byte_go;
    state_ff == S_DECIDE && sel == BOOT_BYTE && !busreq_s;
  endsequence
  property p_byte_start;
    @(posedge REF_CLK_IN) disable iff (!rst_n) s_byte_go |=> BYTE_MEMORY_DMA_START_OUT;
  endproperty
  a_byte_start: assert property (p_byte_start) else $error("byte boot not started"); // R7
  property p_hold_busreq;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state_ff == S_DECIDE && busreq_s && sel != BOOT_NONE) |=> !CORE_RUN_OUT && !BYTE_MEMORY_DMA_START_OUT;
  endproperty
  a_hold_busreq: assert property (p_hold_busreq) else $error("boot with bus request"); // R4
  property p_byte_done;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state_ff == S_BYTE_WAIT && BYTE_MEMORY_DMA_DONE_IN) |=>
        CORE_RUN_OUT && START_ADDR_OUT == 14'h0000 && !START_EXT_OUT;
  endproperty
  a_byte_done: assert property (p_byte_done) else $error("bad start after byte boot"); // R5
  property p_host_hold;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state_ff == S_HOST_WAIT && !PM0_WRITTEN_IN) |=> !CORE_RUN_OUT;
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("ran before host load"); // R10
  property p_noboot;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (state_ff == S_DECIDE && sel == BOOT_NONE) |=> CORE_RUN_OUT && START_EXT_OUT && !BYTE_MEMORY_DMA_START_OUT;
  endproperty
  a_noboot: assert property (p_noboot) else $error("no-boot path wrong"); // R8
  property p_ack_push;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (cfg_ff.host_mode && !cfg_ff.ack_open_drain) |=> HOST_ACK_OE_OUT;
  endproperty
  a_ack_push: assert property (p_ack_push) else $error("ack not driven"); // R12
  property p_ack_od;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      (cfg_ff.host_mode && cfg_ff.ack_open_drain && $stable(cfg_ff) && !ACK_LEVEL_IN) |=> !HOST_ACK_OE_OUT;
  endproperty
  a_ack_od: assert property (p_ack_od) else $error("open drain drove low"); // R13
  property p_cfg;
    @(posedge REF_CLK_IN) disable iff (!rst_n)
      state_ff == S_RUN |-> MEM_CFG_OUT.host_mode == straps_ff.mode_c && MEM_CFG_OUT.ext_exec_ok == !straps_ff.mode_c;
  endproperty
  a_cfg: assert property (p_cfg) else $error("memory mode mismatch"); // R11
endmodule
`default_nettype wire

// ===== rbs_params.svh
// Constants for the reset and boot-mode sequencer
// ----------------------------------------------------------------------------
// Behaviour
// R1: Master reset empties stack pointers, masks all interrupts, clears mode status.
// R2: External reset source holds reset low 2000 input clocks for PLL lock.
// R3: Later resets keep the clock running and add no stabilisation delay.
// R4: Boot only when no bus request is pending and straps select booting.
// R5: After boot, first instruction fetch is internal program address 0x0000.
// R6: Memory-mode strap sampled in reset; pin becomes flag two afterwards.
// R7: Straps B,A low: byte DMA loads 32 words, execution held until done.
// R8: C low, B high, A low: no boot, start at external location 0.
// R9: In no-boot mode byte DMA is usable but never started or awaited.
// R10: C high, A high: host DMA loads memory, hold until program word 0 written. Code also needs B low; C,B,A all high starts unbooted.
// R11: Strap C 0 selects full memory mode, 1 host mode; D ignored in full.
// R12: Host mode with D 0: acknowledge driven actively both ways.
// R13: Host mode with D 1: acknowledge is open drain for wire-OR.
// R14: External strap driver drives the shared pin only while reset is low.
// R15: Host mode limits external overlay addressing to address line A0.
// R16: Host mode forbids executing program code from external memory.
// R17: Reset release synchronised to clock; straps latched on that same edge.
// ----------------------------------------------------------------------------
`ifndef RBS_PARAMS_SVH
`define RBS_PARAMS_SVH
`define RBS_BOOT_WORDS 6'h20
`define RBS_START_INT 14'h0000
`define RBS_START_EXT 14'h0000
`define RBS_MODE_STATUS_RST 7'h00
`define RBS_IMASK_RST 10'h000
`define RBS_SP_EMPTY 4'h0
`define RBS_POWERUP_CYCLES 2000
`endif

// ===== rbs_pkg.sv
// Types for the reset and boot-mode sequencer
package rbs_pkg;
  typedef enum logic [1:0] {BOOT_BYTE, BOOT_HOST, BOOT_NONE, BOOT_BAD} boot_sel_t;
  typedef struct packed {
    logic mode_d;
    logic mode_c;
    logic mode_b;
    logic mode_a;
  } straps_t;
  typedef struct packed {
    logic host_mode;
    logic ack_open_drain;
    logic overlay_a0_only;
    logic ext_exec_ok;
  } mem_cfg_t;
endpackage

// ===== rbs_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module rbs_sync #(parameter int W = 1)
(
  input wire logic clk_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  // First stage feeds only the second; no reset, so pin levels keep flowing while held in reset
  always_ff @(posedge clk_in)
  begin
    s1_ff <= d_in;
    s2_ff <= s1_ff;
  end
  assign q_out = s2_ff;
endmodule
`default_nettype wire

// ===== rbs_rstsync.sv
// Reset synchroniser: async assert, clocked release
`timescale 1ns/100ps
`default_nettype none
module rbs_rstsync
(
  input wire logic clk_in,
  input wire logic rstn_in,
  output logic rstn_out
);
  logic r1_ff;
  logic r2_ff;
  // Release on a clock edge so state leaves reset together
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      r1_ff <= 1'b0;
      r2_ff <= 1'b0;
    end
    else
    begin
      r1_ff <= 1'b1;
      r2_ff <= r1_ff;
    end
  end
  assign rstn_out = r2_ff;
endmodule
`default_nettype wire

// ===== rbs_strap_model.sv
// Board model: strap driver sharing the memory-mode pin with flag two
`timescale 1ns/100ps
`default_nettype none
module rbs_strap_model
(
  input wire logic rstn_in,
  input wire rbs_pkg::straps_t strap_in,
  input wire logic flag_in,
  input wire logic flag_oe_in,
  output var rbs_pkg::straps_t pins_out
);
  import rbs_pkg::*;
  // Driver owns the shared pin only in reset; an undriven pin is shown drifted
  always_comb
  begin
    pins_out = strap_in;
    if (rstn_in && flag_oe_in)
      pins_out.mode_c = flag_in;
    else if (rstn_in)
      pins_out.mode_c = ~strap_in.mode_c;
  end
endmodule
`default_nettype wire

// ===== rbs_top_tb_top.sv
// Self-checking testbench for the reset and boot-mode sequencer
`timescale 1ns/100ps
`default_nettype none
`include "rbs_params.svh"
module rbs_top_tb_top;
  import rbs_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  straps_t strap_val = 4'h0;
  straps_t pins;
  logic bus_req = 1'b0, done = 1'b0, pm0 = 1'b0, ack_lvl = 1'b1;
  logic fval = 1'b0, fdir = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] rdata, d;
  logic run, bstart, sext, ack, ack_oe, fout, foe, fsmp;
  logic [5:0] words;
  logic [13:0] saddr;
  logic [6:0] mode_status;
  logic [9:0] imask;
  logic [3:0] sp;
  mem_cfg_t cfg;
  int miscompares = 0, total_checks = 0, starts = 0;
  logic [3:0] codes [7] = '{4'h2, 4'h4, 4'h5, 4'hC, 4'hD, 4'h8, 4'h3};

  // Free-running clock, 10 ns period
  always #5 clk = ~clk;
  // Start pulses last one cycle, so count them at every edge
  always @(posedge clk) if (bstart === 1'b1) starts++;

  rbs_strap_model rbs_strap_model_i (.rstn_in(rstn), .strap_in(strap_val), .flag_in(fout),
    .flag_oe_in(foe), .pins_out(pins));
  rbs_top rbs_top_i (.REF_CLK_IN(clk), .RSTN_IN(rstn), .STRAPS_IN(pins), .BUS_REQ_IN(bus_req),
    .BYTE_MEMORY_DMA_DONE_IN(done), .PM0_WRITTEN_IN(pm0), .ACK_LEVEL_IN(ack_lvl), .FLAG2_OUT_VAL_IN(fval),
    .FLAG2_OUT_DIR_IN(fdir), .ADDR_WR_IN(addr), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .CORE_RUN_OUT(run), .BYTE_MEMORY_DMA_START_OUT(bstart), .BYTE_MEMORY_DMA_WORDS_OUT(words),
    .START_ADDR_OUT(saddr),
    .START_EXT_OUT(sext), .MODE_STATUS_OUT(mode_status), .IMASK_OUT(imask), .STACK_PTR_OUT(sp),
    .MEM_CFG_OUT(cfg), .HOST_ACK_OUT(ack), .HOST_ACK_OE_OUT(ack_oe), .FLAG2_OUT(fout),
    .FLAG2_OE_OUT(foe), .FLAG2_SAMPLE_OUT(fsmp));

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Settle point is 1 ns after the last edge waited for
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle strobe; read data stand only in the following cycle
  task acc(input logic [3:0] a, input logic is_rd);
    @(posedge clk);
    addr <= a;
    rd_s <= is_rd;
    wr_s <= ~is_rd;
    @(posedge clk);
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    #1 d = rdata;
  endtask

  task boot(input straps_t s, input logic req, input int n);
    logic c, nob, bt, host, bad;
    c = s.mode_c;
    nob = !c && s.mode_b && !s.mode_a;
    bt = !s.mode_b && !s.mode_a;
    host = c && !s.mode_b && s.mode_a;
    bad = !nob && !bt && !host;
    @(posedge clk);
    rstn <= 1'b0;
    strap_val <= s;
    bus_req <= req;
    fdir <= 1'b0;
    ack_lvl <= 1'b1;
    cyc(n);
    chk("mode status", 0, mode_status);
    chk("irq mask", 0, imask);
    chk("stack ptr", 0, sp);
    chk("words", 32, words);
    chk("flag oe", 0, foe);
    @(posedge clk);
    rstn <= 1'b1;
    starts = 0;
    cyc(12);
    chk("run", nob || bad, run);
    chk("dma starts", bt && !req, starts);
    if (req)
    begin
      @(posedge clk);
      bus_req <= 1'b0;
      cyc(10);
      chk("dma starts", 1, starts);
      chk("run", 0, run);
    end
    if (!nob)
    begin
      @(posedge clk);
      done <= bt;
      pm0 <= host;
      @(posedge clk);
      done <= 1'b0;
      pm0 <= 1'b0;
      cyc(3);
      chk("run", 1, run);
    end
    chk("start addr", 0, saddr);
    chk("start ext", nob, sext);
    chk("mem cfg", {c, c & s.mode_d, c, !c}, cfg);
    chk("flag sample", !c, fsmp);
    @(posedge clk);
    ack_lvl <= 1'b0;
    fval <= c;
    fdir <= 1'b1;
    cyc(4);
    chk("ack level", 0, ack);
    chk("ack oe", c && !s.mode_d, ack_oe);
    chk("flag oe", 1, foe);
    chk("flag out", c, fout);
    chk("flag sample", c, fsmp);
    chk("mem cfg", {c, c & s.mode_d, c, !c}, cfg);
    @(posedge clk);
    ack_lvl <= 1'b1;
    cyc(3);
    chk("ack level", 1, ack);
    chk("ack oe", c, ack_oe);
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Main sequence: power-up boot, bus-held boot, then seven further strap codes
  initial
  begin
    boot(4'h0, 1'b0, `RBS_POWERUP_CYCLES);
    boot(4'h0, 1'b1, 5);
    foreach (codes[i])
      boot(codes[i], 1'b0, 5);
    acc(4'h0, 1'b1);
    chk("reg mode status", 0, d);
    acc(4'h0, 1'b0);
    acc(4'hF, 1'b1);
    chk("reg unmapped", 0, d);
    acc(4'h1, 1'b1);
    chk("reg config", 8'h13, d);
    finish_test;
  end

  // Whole run is about 2300 cycles; cut a hang well beyond that
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test;
  end
endmodule
`default_nettype wire
